// ===== design/sic_pkg.sv
package sic_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0]  CTRL_ADDR  = 4'h2;  // word index
  localparam logic [3:0]  STAT_ADDR  = 4'h3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PORT_LSB  = 16;
  localparam int PWRQ_LSB  = 12;
  localparam int ALLOW_LSB = 8;
  localparam int SPEED_LSB = 4;
  localparam int DET_LSB   = 0;

  // ************************************************************
  // field encodings
  // ************************************************************
  localparam logic [3:0] CODE_NONE    = 4'h0;
  localparam logic [3:0] PWRQ_PARTIAL = 4'h1;
  localparam logic [3:0] PWRQ_SLUMBER = 4'h2;
  localparam logic [3:0] PWRQ_ACTIVE  = 4'h4;
  localparam logic [3:0] ALLOW_NO_PAR = 4'h1;
  localparam logic [3:0] ALLOW_NO_SLU = 4'h2;
  localparam logic [3:0] ALLOW_NONE   = 4'h3;
  localparam logic [3:0] SPEED_GEN1   = 4'h1;
  localparam logic [3:0] SPEED_GEN2   = 4'h2;
  localparam logic [3:0] DET_INIT     = 4'h1;
  localparam logic [3:0] DET_OFFLINE  = 4'h4;

  typedef struct packed {
    logic [3:0] mux_port_number;
    logic [3:0] allowed_power_states;
    logic [3:0] speed_limit;
    logic [3:0] detect_init_control;
  } sic_ctrl_t;

  typedef struct packed {
    logic partial;
    logic slumber;
    logic active;
  } sic_pwr_t;

endpackage

// ===== design/sic_control.sv
`timescale 1ns/1ps
// How it works
// - port field drives the outgoing frame port number on every transmit.
// - port field is zero after reset.
// - port field is optional; frame builder may ignore it.
// - power request write of code 1, 2 or 4 gives at most one pulse, never latched.
// - power request field always reads zero.
// - request codes 1 partial, 2 slumber, 4 active; others reserved.
// - allowed field 1 blocks partial, 2 slumber, 3 both.
// - speed field 1 caps at gen1, 2 caps at gen2, 0 no cap.
// - detect code 1 resets interface and reruns link initialization.
// - detect code 1 holds interface in reset until rewritten.
// - detect code 4 takes the phy offline.
// - detect code 0 requests nothing; others reserved.
// - writes act; reads return last value except read-zero fields.
module sic_control (
  input  wire logic        i_clk,             // 40 MHz clock
  input  wire logic        i_resetn,          // async reset, low
  input  wire logic [3:0]  i_address,         // word address
  input  wire logic        i_read,            // read strobe
  input  wire logic        i_write,           // write strobe
  input  wire logic [31:0] i_writedata,       // write data
  input  wire logic [3:0]  i_byteenable,      // byte lanes
  output logic      [31:0] o_readdata,        // read data
  output logic             o_waitrequest,     // stall
  output logic      [3:0]  o_tx_port_number,  // frame port field
  output logic             o_pwr_partial,     // partial request pulse
  output logic             o_pwr_slumber,     // slumber request pulse
  output logic             o_pwr_active,      // active request pulse
  output logic             o_partial_allowed, // partial permitted
  output logic             o_slumber_allowed, // slumber permitted
  output logic             o_gen1_cap,        // cap at gen1
  output logic             o_gen2_cap,        // cap at gen2
  output logic             o_host_reset_state,// interface held reset
  output logic             o_comm_init,       // start init pulse
  output logic             o_phy_offline      // phy offline
);

  // ************************************************************
  // bus handshake
  // ************************************************************
  // one wait cycle per access so read data comes from a flop
  logic              ack_reg, ack_next;
  logic [31:0]       rdata_reg, rdata_next;
  sic_pkg::sic_ctrl_t ctrl_reg, ctrl_next;
  sic_pkg::sic_pwr_t  pwr_reg, pwr_next;
  logic              init_reg, init_next;
  logic              req;
  logic              wr_fire;
  logic [31:0]       wmask;
  logic [31:0]       cur;
  logic [31:0]       merged;
  logic [3:0]        f_pwrq, f_allow, f_speed, f_det;

  assign req           = (i_read | i_write) & ~ack_reg;
  assign o_waitrequest = ~ack_reg;
  assign wr_fire       = i_write & ack_reg;
  assign o_readdata    = rdata_reg;

  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  always_comb begin
    cur = '0;
    cur[sic_pkg::PORT_LSB  +: 4] = ctrl_reg.mux_port_number;
    cur[sic_pkg::ALLOW_LSB +: 4] = ctrl_reg.allowed_power_states;
    cur[sic_pkg::SPEED_LSB +: 4] = ctrl_reg.speed_limit;
    cur[sic_pkg::DET_LSB   +: 4] = ctrl_reg.detect_init_control;
  end

  assign merged  = (i_writedata & wmask) | (cur & ~wmask);
  assign f_pwrq  = i_writedata[sic_pkg::PWRQ_LSB +: 4]
                   & wmask[sic_pkg::PWRQ_LSB +: 4];
  assign f_allow = merged[sic_pkg::ALLOW_LSB +: 4];
  assign f_speed = merged[sic_pkg::SPEED_LSB +: 4];
  assign f_det   = merged[sic_pkg::DET_LSB +: 4];

  // ************************************************************
  // register update
  // ************************************************************
  always_comb begin
    ack_next   = req;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    pwr_next   = '0;
    init_next  = 1'b0;
    if (req && i_read) begin
      if (i_address == sic_pkg::CTRL_ADDR) begin
        rdata_next = cur;
      end else if (i_address == sic_pkg::STAT_ADDR) begin
        rdata_next = {29'h0000_0000, ctrl_reg.detect_init_control
                      == sic_pkg::DET_INIT, ctrl_reg.detect_init_control
                      == sic_pkg::DET_OFFLINE, 1'b0};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    if (wr_fire && i_address == sic_pkg::CTRL_ADDR) begin
      ctrl_next.mux_port_number = merged[sic_pkg::PORT_LSB +: 4];
      // reserved codes leave the previous setting in force
      if (f_allow <= sic_pkg::ALLOW_NONE) begin
        ctrl_next.allowed_power_states = f_allow;
      end
      if (f_speed <= sic_pkg::SPEED_GEN2) begin
        ctrl_next.speed_limit = f_speed;
      end
      if (f_det == sic_pkg::CODE_NONE || f_det == sic_pkg::DET_INIT ||
          f_det == sic_pkg::DET_OFFLINE) begin
        ctrl_next.detect_init_control = f_det;
      end
      // a write that leaves the detect lane off does not restart the link
      if (wmask[sic_pkg::DET_LSB] && f_det == sic_pkg::DET_INIT) begin
        init_next = 1'b1;
      end
      case (f_pwrq)
        sic_pkg::PWRQ_PARTIAL: pwr_next.partial = 1'b1;
        sic_pkg::PWRQ_SLUMBER: pwr_next.slumber = 1'b1;
        sic_pkg::PWRQ_ACTIVE:  pwr_next.active  = 1'b1;
        default:               pwr_next         = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg  <= '{
        mux_port_number:      sic_pkg::CTRL_RESET[sic_pkg::PORT_LSB  +: 4],
        allowed_power_states: sic_pkg::CTRL_RESET[sic_pkg::ALLOW_LSB +: 4],
        speed_limit:          sic_pkg::CTRL_RESET[sic_pkg::SPEED_LSB +: 4],
        detect_init_control:  sic_pkg::CTRL_RESET[sic_pkg::DET_LSB   +: 4]};
      pwr_reg   <= '0;
      init_reg  <= 1'b0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      ctrl_reg  <= ctrl_next;
      pwr_reg   <= pwr_next;
      init_reg  <= init_next;
    end
  end

  // ************************************************************
  // interface controls
  // ************************************************************
  // a frame builder with its own port source may ignore this
  assign o_tx_port_number   = ctrl_reg.mux_port_number;
  // a blocked state drops its pulse rather than queueing it
  assign o_pwr_partial      = pwr_reg.partial & o_partial_allowed;
  assign o_pwr_slumber      = pwr_reg.slumber & o_slumber_allowed;
  assign o_pwr_active       = pwr_reg.active;
  assign o_partial_allowed  = ~ctrl_reg.allowed_power_states[0];
  assign o_slumber_allowed  = ~ctrl_reg.allowed_power_states[1];
  assign o_gen1_cap = ctrl_reg.speed_limit == sic_pkg::SPEED_GEN1;
  assign o_gen2_cap = ctrl_reg.speed_limit == sic_pkg::SPEED_GEN2;
  assign o_host_reset_state = ctrl_reg.detect_init_control
                              == sic_pkg::DET_INIT;
  assign o_comm_init        = init_reg;
  assign o_phy_offline      = ctrl_reg.detect_init_control
                              == sic_pkg::DET_OFFLINE;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_ctrl_write(logic [3:0] code, int lsb);
    wr_fire && i_address == sic_pkg::CTRL_ADDR && i_byteenable[lsb / 8]
      && i_writedata[lsb +: 4] == code;
  endsequence

  a_pulse_one_shot: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_pwr_active |=> !o_pwr_active)
    else $error("power request pulse held");

  a_active_request: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::PWRQ_ACTIVE, sic_pkg::PWRQ_LSB) |=> o_pwr_active)
    else $error("active request lost");

  a_pwrq_reads_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (ack_reg && i_read && i_address == sic_pkg::CTRL_ADDR)
      |-> o_readdata[15:12] == 4'h0)
    else $error("request field read nonzero");

  // entry pulse, then the held level over two more cycles; a back-to-back write can reach the second
  sequence s_reset_hold;
    (o_host_reset_state && o_comm_init) ##1 o_host_reset_state[*2];
  endsequence

  a_reset_holds: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::DET_INIT, sic_pkg::DET_LSB) |=> s_reset_hold)
    else $error("host reset state not held");

  a_offline_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::DET_OFFLINE, sic_pkg::DET_LSB)
      |=> o_phy_offline && !o_host_reset_state)
    else $error("offline not entered");

  a_port_follow: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (wr_fire && i_address == sic_pkg::CTRL_ADDR && i_byteenable[2])
      |=> o_tx_port_number == $past(i_writedata[19:16]))
    else $error("port number not updated");

  a_reserved_ignored: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(4'h7, sic_pkg::SPEED_LSB)
      |=> $stable(ctrl_reg.speed_limit))
    else $error("reserved speed code stored");

  a_partial_blocked: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ctrl_reg.allowed_power_states == sic_pkg::ALLOW_NONE
      |-> !o_pwr_partial && !o_pwr_slumber)
    else $error("blocked power state requested");

  a_gen1_cap: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::SPEED_GEN1, sic_pkg::SPEED_LSB)
      |=> o_gen1_cap && !o_gen2_cap)
    else $error("gen1 cap missing");

  a_idle_noop: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::CODE_NONE, sic_pkg::DET_LSB)
      |=> !o_phy_offline && !o_host_reset_state && !o_comm_init)
    else $error("zero detect code acted");

  a_readback: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (wr_fire && i_address == sic_pkg::CTRL_ADDR && i_byteenable == 4'hf
     && i_writedata[19:16] == 4'h5) ##[2:3] (ack_reg && i_read
     && i_address == sic_pkg::CTRL_ADDR) |-> o_readdata[19:16] == 4'h5)
    else $error("readback mismatch");

  // leaving the held reset state takes a software write
  a_reset_release: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $fell(o_host_reset_state)
      |-> $past(wr_fire && i_address == sic_pkg::CTRL_ADDR))
    else $error("host reset left without a write");

  a_partial_request: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::PWRQ_PARTIAL, sic_pkg::PWRQ_LSB)
      |=> o_pwr_partial == o_partial_allowed)
    else $error("partial request mishandled");

  a_slumber_request: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::PWRQ_SLUMBER, sic_pkg::PWRQ_LSB)
      |=> o_pwr_slumber == o_slumber_allowed)
    else $error("slumber request mishandled");

  a_reserved_request: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(4'h3, sic_pkg::PWRQ_LSB)
      |=> !o_pwr_partial && !o_pwr_slumber && !o_pwr_active)
    else $error("reserved power code acted");

  a_pwr_exclusive: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $onehot0({o_pwr_partial, o_pwr_slumber, o_pwr_active}))
    else $error("two power requests at once");

  a_init_one_shot: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_comm_init |=> !o_comm_init)
    else $error("link restart pulse held");

  a_init_cause: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_comm_init |-> $past(wr_fire && i_address == sic_pkg::CTRL_ADDR
      && i_byteenable[0] && i_writedata[3:0] == sic_pkg::DET_INIT))
    else $error("link restart without a detect write");

  a_gen2_cap: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::SPEED_GEN2, sic_pkg::SPEED_LSB)
      |=> o_gen2_cap && !o_gen1_cap)
    else $error("gen2 cap missing");

  a_no_speed_cap: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::CODE_NONE, sic_pkg::SPEED_LSB)
      |=> !o_gen1_cap && !o_gen2_cap)
    else $error("speed cap left in force");

  a_modes_exclusive: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !(o_host_reset_state && o_phy_offline))
    else $error("reset and offline together");

  a_pulse_after_write: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (o_pwr_partial || o_pwr_slumber || o_pwr_active)
      |-> $past(wr_fire && i_address == sic_pkg::CTRL_ADDR))
    else $error("power pulse without a write");

  a_block_slumber: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_ctrl_write(sic_pkg::ALLOW_NO_SLU, sic_pkg::ALLOW_LSB)
      |=> !o_slumber_allowed && o_partial_allowed)
    else $error("slumber not blocked");

endmodule

// ===== bench/sic_link_dev.sv
`timescale 1ns/1ps
// far-side stand-in: follows power requests and counts link restarts
module sic_link_dev (
  input  wire logic       i_clk,        // clock
  input  wire logic       i_resetn,     // async reset, low
  input  wire logic       i_partial,    // partial request
  input  wire logic       i_slumber,    // slumber request
  input  wire logic       i_active,     // active request
  input  wire logic       i_comm_init,  // init request
  output logic      [1:0] o_pm_state,   // 0 active, 1 partial, 2 slumber
  output logic      [7:0] o_init_count  // init sequences seen
);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pm_state   <= 2'h0;
      o_init_count <= 8'h00;
    end else begin
      if (i_partial) o_pm_state <= 2'h1;
      if (i_slumber) o_pm_state <= 2'h2;
      if (i_active || i_comm_init) o_pm_state <= 2'h0;
      if (i_comm_init) o_init_count <= o_init_count + 8'h01;
    end
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk, resetn, rd_s, wr_s, wt;
  logic [3:0]  addr, be, port, m_port, m_allow, m_speed, m_det;
  logic [31:0] wdata, rdata;
  logic        p_par, p_slu, p_act, a_par, a_slu, g1, g2, hrst, init, offl;
  logic [7:0]  inits;
  logic [1:0]  pm, m_pm;
  logic [31:0] rq[$];
  logic [31:0] pq[$];
  int          fails, num_checks, seed, ninit;
  localparam logic [3:0] C = sic_pkg::CTRL_ADDR;

  sic_control i_sic_control (.i_clk(clk), .i_resetn(resetn), .i_address(addr),
    .i_read(rd_s), .i_write(wr_s), .i_writedata(wdata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wt), .o_tx_port_number(port),
    .o_pwr_partial(p_par), .o_pwr_slumber(p_slu), .o_pwr_active(p_act),
    .o_partial_allowed(a_par), .o_slumber_allowed(a_slu), .o_gen1_cap(g1),
    .o_gen2_cap(g2), .o_host_reset_state(hrst), .o_comm_init(init),
    .o_phy_offline(offl));
  sic_link_dev i_sic_link_dev (.i_clk(clk), .i_resetn(resetn),
    .i_partial(p_par), .i_slumber(p_slu), .i_active(p_act),
    .i_comm_init(init), .o_pm_state(pm), .o_init_count(inits));

  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] ctl();
    return {12'h000, m_port, 4'h0, m_allow, m_speed, m_det};
  endfunction
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] b);
    int n;
    @(posedge clk);
    rd_s <= !w; wr_s <= w; addr <= a; wdata <= d; be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      results();
    end
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  // model first, so expectations exist before the pulse can appear
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] b);
    logic [31:0] e;
    e = 0;
    if (a == C) begin
      if (b[2]) m_port = d[19:16];
      if (b[1] && d[11:8] < 4) m_allow = d[11:8];
      if (b[1] && d[15:12] == 1 && !m_allow[0]) e[0] = 1;
      if (b[1] && d[15:12] == 2 && !m_allow[1]) e[1] = 1;
      if (b[1] && d[15:12] == 4) e[2] = 1;
      if (b[0] && d[7:4] < 3) m_speed = d[7:4];
      if (b[0] && d[3:0] inside {0, 1, 4}) m_det = d[3:0];
      if (b[0] && d[3:0] == 1) e[3] = 1;
      if (e[3]) ninit++;
      if (e[0]) m_pm = 2'h1;
      if (e[1]) m_pm = 2'h2;
      if (e[2] || e[3]) m_pm = 2'h0;
    end
    if (e != 0) pq.push_back(e);
    bus(1'b1, a, d, b);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  task automatic lv;
    @(negedge clk);
    cmp("levels", {22'h0, m_port, !m_allow[0], !m_allow[1], m_speed == 1,
      m_speed == 2, m_det == 1, m_det == 4},
      {22'h0, port, a_par, a_slu, g1, g2, hrst, offl});
  endtask

  always @(posedge clk) begin
    if (rd_s && wt === 1'b0) cmp("readdata", rq.pop_front(), rdata);
    if ({init, p_act, p_slu, p_par} !== 4'h0)
      cmp("pulses", pq.pop_front(), {28'h0, init, p_act, p_slu, p_par});
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    resetn = 0; rd_s = 0; wr_s = 0; addr = 0; wdata = 0; be = 0;
    m_port = 0; m_allow = 0; m_speed = 0; m_det = 0; seed = 59039;
    fails = 0; num_checks = 0; ninit = 0;
    m_pm = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(C, 32'h0000_0000);
    lv();
    repeat (6) begin
      wr(C, $random(seed) & 32'hffff_0fff, 4'hf);
      rd(C, ctl());
      lv();
    end
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    m_port = 0;
    m_allow = 0;
    m_speed = 0;
    m_det = 0;
    m_pm = 0;
    ninit = 0;
    lv();
    wr(C, 32'h0000_0000, 4'hf);
    for (int i = 0; i < 16; i++) begin
      wr(C, i << 12, 4'h2);
      rd(C, ctl());
    end
    for (int j = 0; j < 5; j++) begin
      wr(C, j << 8, 4'h2);
      lv();
      wr(C, (j << 8) | 32'h0000_1000, 4'h2);
      wr(C, (j << 8) | 32'h0000_2000, 4'h2);
    end
    for (int k = 0; k < 16; k++) begin
      wr(C, (k << 4) | k, 4'h1);
      lv();
      rd(sic_pkg::STAT_ADDR, {29'h0, m_det == 1, m_det == 4, 1'b0});
    end
    wr(C, 32'hffff_ffff, 4'h4);
    rd(C, ctl());
    wr(C, 32'h0005_0000, 4'hf);
    rd(C, ctl());
    wr(4'h7, $random(seed), 4'hf);
    rd(4'h7, 32'h0000_0000);
    rd(C, ctl());
    repeat (3) @(posedge clk);
    cmp("inits", ninit, {24'h0, inits});
    cmp("pm state", {30'h0, m_pm}, {30'h0, pm});
    cmp("pending", 0, pq.size() + rq.size());
    results();
  end
endmodule
